// *** core/bcca_pkg.sv ***
package bcca_pkg;
  // Host address map.
  localparam logic [15:0] NO_DRIVE_LO = 16'hB400;
  localparam logic [15:0] NO_DRIVE_HI = 16'hB7FF;
  localparam logic [15:0] MONITOR_A_LO = 16'h8000;
  localparam logic [15:0] MONITOR_A_HI = 16'hB3FF;
  localparam logic [15:0] MONITOR_B_LO = 16'hB800;
  localparam logic [15:0] MONITOR_B_HI = 16'hBFFF;
  localparam logic [15:0] SUPPORT_LO = 16'h2000;
  localparam logic [15:0] SUPPORT_HI = 16'h3FFF;
  localparam logic [15:0] SRAM_LO = 16'hC000;
  localparam logic [15:0] SRAM_HI = 16'hFFFF;
  localparam logic [15:0] ANALYZER_LO = 16'h4000;
  localparam logic [15:0] ANALYZER_HI = 16'h7FFF;
  localparam logic [15:0] SERIAL_LO = 16'hB400;
  localparam logic [15:0] SERIAL_HI = 16'hB40F;
  localparam logic [15:0] SERIAL_RESET_ADDR = 16'hB500;
  localparam logic [15:0] POST_CLEAR_ADDR = 16'hB500;
  localparam logic [15:0] CAPTURE_RD_LO = 16'hB480;
  localparam logic [15:0] CAPTURE_RD_HI = 16'hB4B0;
  localparam logic [15:0] NIBBLE_SHIFT_ADDR = 16'hB490;
  localparam logic [15:0] CHAIN_UP_ADDR = 16'hB4B0;
  localparam logic [15:0] CHAIN_DOWN_ADDR = 16'hB4A0;
  // Lane read addresses inside the capture read window.
  localparam logic [15:0] LANE_AUX_ADDR = 16'hB480;
  localparam logic [15:0] LANE_ADDR_HI_ADDR = 16'hB484;
  localparam logic [15:0] LANE_ADDR_LO_ADDR = 16'hB488;
  localparam logic [15:0] LANE_DATA_ADDR = 16'hB48C;
  // Serial controller register indexes (low address nibble).
  localparam logic [3:0] SER_INPUT_IDX = 4'h0;
  localparam logic [3:0] SER_OUTPUT_IDX = 4'h1;
  localparam logic [3:0] SER_NMI_IDX = 4'h2;
  // Output port fields and reset value.
  localparam int OUT_ACCESS_BIT = 0;
  localparam int OUT_OPTION_BIT = 1;
  localparam logic [7:0] OUT_PORT_RESET = 8'h00;
  localparam logic [15:0] CHAIN_RESET = 16'h0000;
  localparam int AUX_SELECT_BIT = 14;
  localparam int TEST_SELECT_BIT = 15;
  localparam int TRIGGER_DATA_BIT = 7;
  // Host end APB registers.
  localparam logic [7:0] HOST_ADDR_REG = 8'h00;
  localparam logic [7:0] HOST_DATA_REG = 8'h04;
  localparam logic [7:0] HOST_CTRL_REG = 8'h08;
  localparam logic [7:0] HOST_STATUS_REG = 8'h0C;
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_FETCH_BIT = 1;
  localparam logic [31:0] APB_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {
    BCCA_IDLE = 2'b00,
    BCCA_STROBE = 2'b01,
    BCCA_WAIT = 2'b10,
    BCCA_TAKE = 2'b11
  } bcca_host_state_type;
endpackage : bcca_pkg

// *** core/bcca_bus_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface bcca_bus_if;
  logic [15:0] addr;
  logic readCycle;
  logic cycleStrobe;
  logic instructionFetchLine;
  logic [7:0] hostData;
  logic hostDataOe;
  logic [7:0] devData;
  logic devDataOe;
  logic nonMaskableInterrupt;
  logic [7:0] dataBus;
  // Resolved shared data bus; pull-up when nobody drives.
  assign dataBus = hostDataOe ? hostData : (devDataOe ? devData : 8'hFF);
  modport device (input addr, input readCycle, input cycleStrobe, input instructionFetchLine,
    input dataBus, output devData, output devDataOe, output nonMaskableInterrupt);
  modport host (output addr, output readCycle, output cycleStrobe, output instructionFetchLine,
    output hostData, output hostDataOe, input dataBus, input nonMaskableInterrupt);
endinterface : bcca_bus_if
`default_nettype wire

// *** core/bcca_device.sv ***
// What this block does
// - Decoder splits space into 16K read/write selects.
// - No decoder output inside B400 to B7FF.
// - Monitor memory on reads 8000-B3FF, B800-BFFF.
// - Support memory on reads 2000-3FFF.
// - Static RAM selected read/write C000-FFFF.
// - 4000-7FFF write triggers store, read test strobe.
// - Serial at B400-B40F; read B500 resets it.
// - Capture read, nibble shift, post-trigger clear strobes.
// - Serial raises interrupt on terminal key.
// - Serial reads six jumper inputs.
// - Serial eight-bit output drives mode bits.
// - Capture buffer 32 bits, 8K, four lanes.
// - Lanes share address from low 13 bits.
// - Aux lane holds user bits or test byte.
// - Access mode enables lanes; four read addresses.
// - 16-bit chain; top bits pick aux source.
// - Direction follows count-down decode.
// - Nibble shift loads top, neighbours shift down.
// - Chain steps on pulses outside access mode, reads B4B0/B4A0.
// - Reads of 4000-7FFF return test byte.
// - Trigger memory 16K x 1 stores D7.
// - Trigger asserts on marked bus addresses.
`timescale 1ns/10ps
`default_nettype none
module bcca_device #(
  parameter int DEPTH = 8192,
  parameter int TRIG_DEPTH = 16384
) (
  input wire logic clk,
  input wire logic rst,
  bcca_bus_if.device bus,
  input wire logic [5:0] jumperInputs,
  input wire logic keyArrived,
  input wire logic [5:0] userTestInputs,
  input wire logic chainStepPulse,
  input wire logic captureWriteStrobe,
  input wire logic [3:0] stateBits,
  input wire logic postTriggerStep,
  input wire logic postTriggerHalfFlag,
  input wire logic postTriggerFullFlag,
  output logic [3:0] readBlockSelect,
  output logic [3:0] writeBlockSelect,
  output logic monitorMemSelect,
  output logic supportMemSelect,
  output logic sramSelect,
  output logic serialSelect,
  output logic serialResetPulse,
  output logic triggerMemWriteStrobe,
  output logic testByteReadStrobe,
  output logic captureReadStrobe,
  output logic nibbleShiftStrobe,
  output logic postTriggerClear,
  output logic countDownSelect,
  output logic triggerOut,
  output logic analyzerHostAccess,
  output logic sequencerOptionBit,
  output logic [5:0] bankSelect,
  output logic [3:0] stateLoadNibble,
  output logic [15:0] chainValue
);
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  logic cyc;
  logic rd;
  logic wr;
  logic [15:0] a;
  logic [7:0] busData;
  logic quiet;
  logic [7:0] outPort_q;
  logic nmiEnable_q;
  logic nmiFlag_q;
  logic [15:0] chain_q;
  logic [3:0] stateLoad_q;
  logic [31:0] capture_q [DEPTH];
  logic trig_q [TRIG_DEPTH];
  logic [7:0] devData_q;
  logic devDataOe_q;
  logic [7:0] testByte;
  logic [7:0] auxByte;
  logic [7:0] laneIn;
  logic [31:0] entry;
  logic serialNmiRead;
  logic upRead;
  logic downRead;
  logic accessMode;

  assign cyc = bus.cycleStrobe;
  assign a = bus.addr;
  assign rd = cyc && bus.readCycle;
  assign wr = cyc && !bus.readCycle;
  assign busData = bus.dataBus;
  assign accessMode = outPort_q[bcca_pkg::OUT_ACCESS_BIT];

  // Main decoder: silent over the window where internal memory answers.
  assign quiet = inRange(a, bcca_pkg::NO_DRIVE_LO, bcca_pkg::NO_DRIVE_HI);
  always_comb begin
    readBlockSelect = 4'h0;
    writeBlockSelect = 4'h0;
    if (!quiet) begin
      readBlockSelect[a[15:14]] = rd;
      writeBlockSelect[a[15:14]] = wr;
    end
  end
  assign monitorMemSelect = rd && (inRange(a, bcca_pkg::MONITOR_A_LO, bcca_pkg::MONITOR_A_HI)
    || inRange(a, bcca_pkg::MONITOR_B_LO, bcca_pkg::MONITOR_B_HI));
  assign supportMemSelect = rd && inRange(a, bcca_pkg::SUPPORT_LO, bcca_pkg::SUPPORT_HI);
  assign sramSelect = cyc && inRange(a, bcca_pkg::SRAM_LO, bcca_pkg::SRAM_HI);
  assign triggerMemWriteStrobe = wr && inRange(a, bcca_pkg::ANALYZER_LO, bcca_pkg::ANALYZER_HI);
  assign testByteReadStrobe = rd && inRange(a, bcca_pkg::ANALYZER_LO, bcca_pkg::ANALYZER_HI);

  // Secondary decoder.
  assign serialSelect = cyc && inRange(a, bcca_pkg::SERIAL_LO, bcca_pkg::SERIAL_HI);
  assign serialResetPulse = rd && (a == bcca_pkg::SERIAL_RESET_ADDR);
  assign captureReadStrobe = rd && inRange(a, bcca_pkg::CAPTURE_RD_LO, bcca_pkg::CAPTURE_RD_HI);
  assign nibbleShiftStrobe = wr && (a == bcca_pkg::NIBBLE_SHIFT_ADDR);
  assign postTriggerClear = wr && (a == bcca_pkg::POST_CLEAR_ADDR);
  assign upRead = rd && (a == bcca_pkg::CHAIN_UP_ADDR);
  assign downRead = rd && (a == bcca_pkg::CHAIN_DOWN_ADDR);
  assign countDownSelect = downRead;
  assign serialNmiRead = serialSelect && rd && (a[3:0] == bcca_pkg::SER_NMI_IDX);

  // Serial controller output port; its own reset pulse restores defaults.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outPort_q <= bcca_pkg::OUT_PORT_RESET;
    end else if (serialResetPulse) begin
      outPort_q <= bcca_pkg::OUT_PORT_RESET;
    end else if (serialSelect && wr && a[3:0] == bcca_pkg::SER_OUTPUT_IDX) begin
      outPort_q <= busData;
    end
  end
  assign analyzerHostAccess = outPort_q[bcca_pkg::OUT_ACCESS_BIT];
  assign sequencerOptionBit = outPort_q[bcca_pkg::OUT_OPTION_BIT];
  assign bankSelect = outPort_q[7:2];

  // Key interrupt: armed only after the host enables it; a key in the clearing cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmiEnable_q <= 1'b0;
    end else if (serialResetPulse) begin
      nmiEnable_q <= 1'b0;
    end else if (serialSelect && wr && a[3:0] == bcca_pkg::SER_NMI_IDX) begin
      nmiEnable_q <= busData[0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmiFlag_q <= 1'b0;
    end else if (keyArrived && nmiEnable_q) begin
      nmiFlag_q <= 1'b1;
    end else if (serialNmiRead || serialResetPulse) begin
      nmiFlag_q <= 1'b0;
    end
  end
  assign bus.nonMaskableInterrupt = nmiFlag_q;

  // Counter chain plus the state-counter nibble beyond its low end.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain_q <= bcca_pkg::CHAIN_RESET;
      stateLoad_q <= 4'h0;
    end else if (nibbleShiftStrobe) begin
      chain_q <= {busData[3:0], chain_q[15:4]};
      stateLoad_q <= chain_q[3:0];
    end else if (downRead) begin
      chain_q <= chain_q - 16'h0001;
    end else if (upRead) begin
      chain_q <= chain_q + 16'h0001;
    end else if (chainStepPulse && !accessMode) begin
      chain_q <= chain_q + 16'h0001;
    end
  end
  assign chainValue = chain_q;
  assign stateLoadNibble = stateLoad_q;

  // Auxiliary lane source picked by the two top chain bits.
  assign testByte = {triggerOut, postTriggerFullFlag, postTriggerHalfFlag, postTriggerStep, stateBits};
  assign auxByte = {userTestInputs, bus.readCycle, !bus.instructionFetchLine};
  always_comb begin
    if (chain_q[bcca_pkg::AUX_SELECT_BIT]) begin
      laneIn = auxByte;
    end else if (chain_q[bcca_pkg::TEST_SELECT_BIT]) begin
      laneIn = testByte;
    end else begin
      laneIn = 8'h00;
    end
  end

  // One entry per recorded cycle, at the address before any step of this edge.
  always_ff @(posedge clk) begin
    if (captureWriteStrobe && !accessMode) begin
      capture_q[chain_q[12:0]] <= {laneIn, a[15:8], a[7:0], busData};
    end
  end
  assign entry = capture_q[chain_q[12:0]];

  // Trigger memory.
  always_ff @(posedge clk) begin
    if (triggerMemWriteStrobe) begin
      trig_q[a[13:0]] <= busData[bcca_pkg::TRIGGER_DATA_BIT];
    end
  end
  assign triggerOut = cyc && trig_q[a[13:0]];

  // Read answers arrive one cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      devData_q <= 8'h00;
      devDataOe_q <= 1'b0;
    end else begin
      devDataOe_q <= 1'b0;
      devData_q <= 8'h00;
      if (testByteReadStrobe) begin
        devDataOe_q <= 1'b1;
        devData_q <= testByte;
      end else if (serialSelect && rd) begin
        devDataOe_q <= 1'b1;
        case (a[3:0])
          bcca_pkg::SER_INPUT_IDX: devData_q <= {2'b00, jumperInputs};
          bcca_pkg::SER_OUTPUT_IDX: devData_q <= outPort_q;
          bcca_pkg::SER_NMI_IDX: devData_q <= {6'h00, nmiFlag_q, nmiEnable_q};
          default: devData_q <= 8'h00;
        endcase
      end else if (captureReadStrobe && accessMode) begin
        devDataOe_q <= 1'b1;
        case (a)
          bcca_pkg::LANE_AUX_ADDR: devData_q <= entry[31:24];
          bcca_pkg::LANE_ADDR_HI_ADDR: devData_q <= entry[23:16];
          bcca_pkg::LANE_ADDR_LO_ADDR: devData_q <= entry[15:8];
          bcca_pkg::LANE_DATA_ADDR: devData_q <= entry[7:0];
          default: devDataOe_q <= 1'b0;
        endcase
      end
    end
  end
  assign bus.devData = devData_q;
  assign bus.devDataOe = devDataOe_q;
endmodule : bcca_device
`default_nettype wire

// *** core/bcca_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module bcca_host (
  input wire logic clk,
  input wire logic rst,
  bcca_bus_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  bcca_pkg::bcca_host_state_type state_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  logic read_q;
  logic fetch_q;
  logic [7:0] result_q;
  logic busy;
  logic access;
  logic go;

  assign access = psel && penable;
  assign busy = (state_q != bcca_pkg::BCCA_IDLE);
  // A start while a cycle runs is dropped; software polls the busy bit.
  assign go = access && pwrite && paddr == bcca_pkg::HOST_CTRL_REG && !busy;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end else if (access && pwrite && paddr == bcca_pkg::HOST_ADDR_REG) begin
      addr_q <= pwdata[15:0];
    end else if (access && pwrite && paddr == bcca_pkg::HOST_DATA_REG) begin
      data_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      read_q <= 1'b1;
      fetch_q <= 1'b0;
    end else if (go) begin
      read_q <= pwdata[bcca_pkg::CTRL_READ_BIT];
      fetch_q <= pwdata[bcca_pkg::CTRL_FETCH_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bcca_pkg::BCCA_IDLE;
    end else begin
      case (state_q)
        bcca_pkg::BCCA_IDLE: if (go) state_q <= bcca_pkg::BCCA_STROBE;
        bcca_pkg::BCCA_STROBE: state_q <= bcca_pkg::BCCA_WAIT;
        bcca_pkg::BCCA_WAIT: state_q <= bcca_pkg::BCCA_TAKE;
        bcca_pkg::BCCA_TAKE: state_q <= bcca_pkg::BCCA_IDLE;
        default: state_q <= bcca_pkg::BCCA_IDLE;
      endcase
    end
  end

  // Read data is valid on the bus in the cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= 8'h00;
    end else if (state_q == bcca_pkg::BCCA_WAIT && read_q) begin
      result_q <= bus.dataBus;
    end
  end

  assign bus.addr = addr_q;
  assign bus.readCycle = read_q;
  assign bus.cycleStrobe = (state_q == bcca_pkg::BCCA_STROBE);
  assign bus.instructionFetchLine = fetch_q;
  assign bus.hostData = data_q;
  assign bus.hostDataOe = (state_q == bcca_pkg::BCCA_STROBE) && !read_q;

  always_comb begin
    case (paddr)
      bcca_pkg::HOST_ADDR_REG: prdata = {16'h0000, addr_q};
      bcca_pkg::HOST_DATA_REG: prdata = {24'h00_0000, data_q};
      bcca_pkg::HOST_CTRL_REG: prdata = {30'h0000_0000, fetch_q, read_q};
      bcca_pkg::HOST_STATUS_REG: prdata = {16'h0000, result_q, 6'h00, bus.nonMaskableInterrupt, busy};
      default: prdata = bcca_pkg::APB_UNMAPPED;
    endcase
  end
endmodule : bcca_host
`default_nettype wire

// *** verif/bcca_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module bcca_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic readCycle,
  input wire logic cycleStrobe,
  input wire logic [7:0] dataBus,
  input wire logic devDataOe,
  input wire logic [3:0] readBlockSelect,
  input wire logic [3:0] writeBlockSelect,
  input wire logic monitorMemSelect,
  input wire logic supportMemSelect,
  input wire logic sramSelect,
  input wire logic serialSelect,
  input wire logic triggerMemWriteStrobe,
  input wire logic testByteReadStrobe,
  input wire logic captureReadStrobe,
  input wire logic nibbleShiftStrobe,
  input wire logic chainStepPulse,
  input wire logic analyzerHostAccess,
  input wire logic serialResetPulse,
  input wire logic postTriggerClear,
  input wire logic countDownSelect,
  input wire logic triggerOut,
  input wire logic [15:0] chainValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  function automatic logic inR(logic [15:0] a, lo, hi);
    return a >= lo && a <= hi;
  endfunction : inR
  logic [15:0] chainPrev_q;
  logic [7:0] busPrev_q;
  logic hole, rd, wr;
  // One-cycle history, so shift and step results can be tied to the value they started from.
  always_ff @(posedge clk) begin
    chainPrev_q <= chainValue;
    busPrev_q <= dataBus;
  end
  assign hole = inR(addr, 16'hB400, 16'hB7FF);
  assign rd = cycleStrobe && readCycle;
  assign wr = cycleStrobe && !readCycle;
  sequence testRead;
    rd && inR(addr, 16'h4000, 16'h7FFF);
  endsequence
  sequence quietRead;
    rd && !hole && !inR(addr, 16'h4000, 16'h7FFF);
  endsequence
  chk_block_decode: assert property (
    cycleStrobe |-> readBlockSelect == (rd && !hole ? 4'h1 << addr[15:14] : 4'h0)
    && writeBlockSelect == (wr && !hole ? 4'h1 << addr[15:14] : 4'h0)) else $error("block select wrong");
  chk_hole_quiet: assert property (
    cycleStrobe && hole |-> !monitorMemSelect && !supportMemSelect && !sramSelect) else $error("hole selected");
  chk_monitor_read: assert property (
    cycleStrobe |-> monitorMemSelect == (rd && (inR(addr, 16'h8000, 16'hB3FF) || inR(addr, 16'hB800, 16'hBFFF))))
    else $error("monitor select wrong");
  chk_support_read: assert property (
    cycleStrobe |-> supportMemSelect == (rd && inR(addr, 16'h2000, 16'h3FFF))) else $error("support select wrong");
  chk_sram_both: assert property (
    cycleStrobe |-> sramSelect == inR(addr, 16'hC000, 16'hFFFF)) else $error("sram select wrong");
  chk_analyzer_strobes: assert property (
    cycleStrobe |-> triggerMemWriteStrobe == (wr && inR(addr, 16'h4000, 16'h7FFF))
    && testByteReadStrobe == (rd && inR(addr, 16'h4000, 16'h7FFF))) else $error("analyzer strobe wrong");
  chk_serial_range: assert property (
    cycleStrobe |-> serialSelect == inR(addr, 16'hB400, 16'hB40F)) else $error("serial select wrong");
  chk_capture_strobes: assert property (
    cycleStrobe |-> captureReadStrobe == (rd && inR(addr, 16'hB480, 16'hB4B0))
    && nibbleShiftStrobe == (wr && addr == 16'hB490)) else $error("capture strobe wrong");
  chk_secondary_pulses: assert property (
    cycleStrobe |-> serialResetPulse == (rd && addr == 16'hB500) && postTriggerClear == (wr && addr == 16'hB500)
    && countDownSelect == (rd && addr == 16'hB4A0)) else $error("secondary pulse wrong");
  chk_trigger_gated: assert property (
    !cycleStrobe |-> !triggerOut) else $error("trigger outside bus cycle");
  chk_test_answer: assert property (
    testRead |=> devDataOe) else $error("test byte not driven");
  chk_quiet_answer: assert property (
    quietRead |=> !devDataOe) else $error("device drove foreign read");
  chk_nibble_load: assert property (
    nibbleShiftStrobe |=> chainValue == {busPrev_q[3:0], chainPrev_q[15:4]}) else $error("nibble shift wrong");
  chk_seq_step: assert property (
    chainStepPulse && !analyzerHostAccess && !captureReadStrobe && !nibbleShiftStrobe
    |=> chainValue == chainPrev_q + 16'h0001) else $error("chain did not step");
  chk_seq_blocked: assert property (
    chainStepPulse && analyzerHostAccess && !captureReadStrobe && !nibbleShiftStrobe
    |=> chainValue == chainPrev_q) else $error("chain stepped in access mode");
  chk_host_down: assert property (
    rd && addr == 16'hB4A0 |=> chainValue == chainPrev_q - 16'h0001) else $error("chain did not count down");
endmodule : bcca_monitor
`default_nettype wire

// *** verif/tb_bus_cycle_capture_analyzer.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_bus_cycle_capture_analyzer;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, keyArrived, chainStepPulse, captureWriteStrobe;
  logic postTriggerStep, postTriggerHalfFlag, postTriggerFullFlag, monitorMemSelect, supportMemSelect;
  logic sramSelect, serialSelect, serialResetPulse, triggerMemWriteStrobe, testByteReadStrobe, captureReadStrobe;
  logic nibbleShiftStrobe, postTriggerClear, countDownSelect, triggerOut, analyzerHostAccess, sequencerOptionBit;
  logic [7:0] paddr, res;
  logic [31:0] pwdata, prdata, word;
  logic [5:0] jumperInputs, userTestInputs, bankSelect;
  logic [3:0] stateBits, readBlockSelect, writeBlockSelect, stateLoadNibble;
  logic [15:0] chainValue;
  int errors, testsRun, cycles;
  bcca_bus_if bus ();
  bcca_device bcca_device_inst (.clk, .rst, .bus(bus), .jumperInputs, .keyArrived, .userTestInputs,
    .chainStepPulse, .captureWriteStrobe, .stateBits, .postTriggerStep, .postTriggerHalfFlag,
    .postTriggerFullFlag, .readBlockSelect, .writeBlockSelect, .monitorMemSelect, .supportMemSelect,
    .sramSelect, .serialSelect, .serialResetPulse, .triggerMemWriteStrobe, .testByteReadStrobe,
    .captureReadStrobe, .nibbleShiftStrobe, .postTriggerClear, .countDownSelect, .triggerOut,
    .analyzerHostAccess, .sequencerOptionBit, .bankSelect, .stateLoadNibble, .chainValue);
  bcca_host bcca_host_inst (.clk, .rst, .bus(bus), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  bcca_monitor bcca_monitor_inst (.clk, .rst, .addr(bus.addr), .readCycle(bus.readCycle),
    .cycleStrobe(bus.cycleStrobe), .dataBus(bus.dataBus), .devDataOe(bus.devDataOe), .readBlockSelect,
    .writeBlockSelect, .monitorMemSelect, .supportMemSelect, .sramSelect, .serialSelect,
    .triggerMemWriteStrobe, .testByteReadStrobe, .captureReadStrobe, .nibbleShiftStrobe,
    .chainStepPulse, .analyzerHostAccess, .serialResetPulse, .postTriggerClear, .countDownSelect, .triggerOut,
    .chainValue);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, testsRun);
    if (errors == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // A hung handshake must still reach the verdict.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check16
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // With cap set, the capture and step pulses land in the strobe cycle of this bus cycle.
  task automatic bus_op(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic cap);
    logic [31:0] s;
    int n;
    apb(1'b1, 8'h00, {16'h0000, a}, s);
    apb(1'b1, 8'h04, {24'h00_0000, d}, s);
    apb(1'b1, 8'h08, {30'h0000_0000, cap, rd}, s);
    if (cap) begin
      captureWriteStrobe <= 1'b1;
      chainStepPulse <= 1'b1;
      @(posedge clk);
      captureWriteStrobe <= 1'b0;
      chainStepPulse <= 1'b0;
    end
    n = 0;
    do begin
      apb(1'b0, 8'h0C, 32'h0000_0000, s);
      n++;
    end while (s[0] !== 1'b0 && n < 20);
    if (n == 20) errors++;
    res = s[15:8];
  endtask : bus_op
  task automatic t_decode();
    logic [15:0] q[8];
    q = '{16'h0000, 16'h3FFF, 16'h8000, 16'hB3FF, 16'hB600, 16'hB7FF, 16'hB800, 16'hFFFF};
    foreach (q[i]) begin
      bus_op(q[i], 8'h00, 1'b1, 1'b0);
      check8(res, 8'hFF);
      bus_op(q[i], 8'h00, 1'b0, 1'b0);
    end
    apb(1'b0, 8'h10, 32'h0000_0000, word);
    check8(word[7:0], bcca_pkg::APB_UNMAPPED[7:0]);
    check8({7'h00, pslverr}, 8'h00);
  endtask : t_decode
  task automatic t_trigger();
    stateBits <= 4'hA;
    postTriggerHalfFlag <= 1'b1;
    bus_op(16'h4000, 8'h80, 1'b0, 1'b0);
    bus_op(16'h4001, 8'h7F, 1'b0, 1'b0);
    bus_op(16'h4000, 8'h00, 1'b1, 1'b0);
    check8(res, 8'hAA);
    bus_op(16'h4001, 8'h00, 1'b1, 1'b0);
    check8(res, 8'h2A);
  endtask : t_trigger
  task automatic t_serial();
    jumperInputs <= 6'h2B;
    bus_op(16'hB400, 8'h00, 1'b1, 1'b0);
    check8({2'b00, res[5:0]}, 8'h2B);
    bus_op(16'hB401, 8'h83, 1'b0, 1'b0);
    check8({bankSelect, sequencerOptionBit, analyzerHostAccess}, 8'h83);
    bus_op(16'hB402, 8'h01, 1'b0, 1'b0);
    keyArrived <= 1'b1;
    @(posedge clk);
    keyArrived <= 1'b0;
    repeat (3) @(posedge clk);
    check8({7'h00, bus.nonMaskableInterrupt}, 8'h01);
    bus_op(16'hB402, 8'h00, 1'b1, 1'b0);
    check8({5'h00, res[1:0], bus.nonMaskableInterrupt}, 8'h06);
    bus_op(16'hB500, 8'h00, 1'b1, 1'b0);
    check8({bankSelect, sequencerOptionBit, analyzerHostAccess}, 8'h00);
    // A write to the same address clears the post-trigger counter; the monitor judges the strobe.
    bus_op(16'hB500, 8'h00, 1'b0, 1'b0);
  endtask : t_serial
  task automatic t_chain();
    logic [15:0] la[4];
    logic [7:0] exp[4];
    la = '{16'hB480, 16'hB484, 16'hB488, 16'hB48C};
    exp = '{8'hB4, 8'hC1, 8'h23, 8'h5A};
    foreach (exp[i]) bus_op(16'hB490, 8'hF7 & {4'hF, la[i][3:0] == 4'h0 ? 4'h7 : 4'h0}, 1'b0, 1'b0);
    bus_op(16'hB490, 8'h04, 1'b0, 1'b0);
    check16(chainValue, 16'h4000);
    check8({4'h0, stateLoadNibble}, 8'h07);
    userTestInputs <= 6'h2D;
    bus_op(16'hC123, 8'h5A, 1'b0, 1'b1);
    check16(chainValue, 16'h4001);
    bus_op(16'hB401, 8'h01, 1'b0, 1'b0);
    chainStepPulse <= 1'b1;
    @(posedge clk);
    chainStepPulse <= 1'b0;
    @(posedge clk);
    check16(chainValue, 16'h4001);
    bus_op(16'hB4A0, 8'h00, 1'b1, 1'b0);
    check16(chainValue, 16'h4000);
    foreach (la[i]) begin
      bus_op(la[i], 8'h00, 1'b1, 1'b0);
      check8(res, exp[i]);
    end
    bus_op(16'hB4B0, 8'h00, 1'b1, 1'b0);
    check16(chainValue, 16'h4001);
  endtask : t_chain
  initial begin
    {rst, psel, penable, pwrite, keyArrived, chainStepPulse, captureWriteStrobe} = 7'h01 << 6;
    {postTriggerStep, postTriggerHalfFlag, postTriggerFullFlag, stateBits} = 7'h00;
    {paddr, pwdata, jumperInputs, userTestInputs} = 52'h0_0000_0000_0000;
    errors = 0;
    testsRun = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_decode();
    t_trigger();
    t_serial();
    t_chain();
    tally_and_finish();
  end
endmodule : tb_bus_cycle_capture_analyzer
`default_nettype wire
